// ===== verilog/slp_pkg.sv
// Purpose: constants shared by the serial link protocol control block
// Assumes: 250 MHz pclk, APB3 register access, 32-bit data
// Notes:   the function list below matches the tags used in the design
//
// Function
// RULE1: with local-station priority, received characters are refused while our transmission is in progress.
// RULE2: with no priority level, transmit and receive run together and neither blocks the other.
// RULE3: a send break timeout of 0 to 3276.7 s in 100 ms steps aborts a stalled transmission.
// RULE4: a receive monitoring time of 0 to 3276.7 s in 100 ms steps supervises an open receive block.
// RULE5: in full-duplex operation an extra interval of 1 to 32767 ms in 1 ms steps is provided.
// RULE6: with the ready option on, the terminal ready pin stays asserted, otherwise it is not driven ready.
// RULE7: the data set ready input is either ignored or must be on before transmission proceeds.
// RULE8: in transparent mode text bytes pass unchanged in both directions.
// RULE9: in conversion mode bytes go out as two ASCII hex characters and come back decoded to binary.
// RULE10: the block check is none, horizontal even or horizontal odd parity, appended on send and checked on receive.
// RULE11: modem control can be automatic, besides the separately settable send request and ready outputs.
// RULE12: expiry of the send break timeout or receive monitoring time sets a readable, clearable status flag.
package slp_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam int UNIT_MS       = 100;              // coarse timer unit in ms

  localparam int TIME_W        = 15;               // 0..32767 units

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_BRK_TO = 8'h04;
  localparam logic [7:0] OFS_RX_MON = 8'h08;
  localparam logic [7:0] OFS_FDX_IV = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK   = 8'h14;
  localparam logic [7:0] OFS_TXDATA = 8'h18;
  localparam logic [7:0] OFS_RXDATA = 8'h1c;
  localparam logic [7:0] OFS_CMD    = 8'h20;
  localparam logic [7:0] OFS_STATE  = 8'h24;

  // control fields
  localparam int CTL_PRIO  = 0;                    // 2 bits
  localparam int CTL_READY = 2;
  localparam int CTL_DSR   = 3;
  localparam int CTL_AUTO  = 4;
  localparam int CTL_RTS   = 5;
  localparam int CTL_CONV  = 6;
  localparam int CTL_BCC   = 7;                    // 2 bits
  localparam int CTL_W     = 9;
  localparam logic [CTL_W-1:0] CTRL_RST = 9'h000;

  localparam logic [1:0] PRIO_NONE   = 2'h0;
  localparam logic [1:0] PRIO_LOCAL  = 2'h1;
  localparam logic [1:0] PRIO_REMOTE = 2'h2;
  localparam logic [1:0] BCC_NONE    = 2'h0;
  localparam logic [1:0] BCC_EVEN    = 2'h1;
  localparam logic [1:0] BCC_ODD     = 2'h2;

  // status bits
  localparam int ST_BRK    = 0;
  localparam int ST_RXMON  = 1;
  localparam int ST_FDX    = 2;
  localparam int ST_BCC    = 3;
  localparam int ST_REFUSE = 4;
  localparam int ST_RXAV   = 5;
  localparam int ST_OVR    = 6;
  localparam int ST_HEX    = 7;
  localparam int NSTS      = 8;

  localparam int CMD_SEND_BCC = 0;
  localparam int CMD_RX_CHK   = 1;

  localparam logic [TIME_W-1:0] TIME_RST = 15'h0000;
  localparam int NTIMER = 3;                       // 0 break, 1 rx monitor, 2 full-duplex interval

endpackage

// ===== verilog/interval_timer.sv
// Purpose: counts ticks up to a programmable limit and pulses on expiry
// Assumes: tick is a one-cycle pulse on the same clock
// Notes:   a limit of zero disables the timer
module interval_timer
  import slp_pkg::*;
#(
  parameter int W = TIME_W
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         run,
  input  wire logic         restart,
  input  wire logic         tick,
  input  wire logic [W-1:0] limit,
  output logic              expired
);

  logic [W-1:0] cnt_ff;
  logic         expired_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff     <= '0;
      expired_ff <= 1'b0;
    end else begin
      expired_ff <= 1'b0;
      if (!run || restart) begin
        cnt_ff <= '0;
      end else if (tick && limit != '0) begin
        if (cnt_ff == limit - W'(1)) begin
          cnt_ff     <= '0;
          expired_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + W'(1);
        end
      end
    end
  end

  assign expired = expired_ff;

endmodule

// ===== verilog/serial_link_protocol_control.sv
// Purpose: protocol control for a free-running serial link, APB register slave
// Assumes: character framer on pclk drives rx_char_* and takes tx_char_*
// Notes:   dataset_ready_in is a pin and is synchronised before use
//
// Our own choices: the APB slave port and the address map.
module serial_link_protocol_control
  import slp_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic [7:0]       tx_char,
  output logic             tx_char_valid,
  input  wire logic        tx_char_ready,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_char_valid,
  output logic             send_request_out,
  output logic             terminal_ready_out,
  input  wire logic        dataset_ready_in
);

  typedef enum logic [1:0] {TX_IDLE, TX_HI, TX_LO, TX_CHK} tx_state_t;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction

  logic [CTL_W-1:0]  ctrl_ff;
  logic [TIME_W-1:0] lim_ff [NTIMER];
  logic [NSTS-1:0]   sts_ff, mask_ff, sts_set;
  logic [7:0]        tx_hold_ff, rx_data_ff, tx_char_ff, tx_par_ff, rx_par_ff;
  logic [3:0]        tx_lo_ff, rx_hi_ff;
  logic              hold_full_ff, bcc_req_ff, rx_chk_ff, rx_full_ff, rx_half_ff, rx_active_ff;
  logic              tx_valid_ff, rts_ff, ready_ff, irq_ff, pready_ff, pslverr_ff;
  logic [31:0]       prdata_ff, nxt_prdata;
  logic              nxt_err;
  logic              dsr_meta_ff, dsr_ff;
  tx_state_t         tx_state_ff;
  logic [17:0]       ms_cnt_ff;
  logic [6:0]        unit_cnt_ff;
  logic              ms_tick_ff, unit_tick_ff;
  logic [NTIMER-1:0] t_run, t_restart, t_tick, t_exp;

  wire [1:0] prio     = ctrl_ff[CTL_PRIO +: 2];
  wire [1:0] bcc_mode = ctrl_ff[CTL_BCC +: 2];
  wire       conv     = ctrl_ff[CTL_CONV];
  wire       wr_acc   = psel && penable && pready_ff && pwrite;
  wire       rd_acc   = psel && penable && pready_ff && !pwrite;
  wire       dsr_ok   = !ctrl_ff[CTL_DSR] || dsr_ff;                        // RULE7
  wire       tx_busy  = hold_full_ff || tx_valid_ff || bcc_req_ff;
  wire       tx_take  = tx_valid_ff && tx_char_ready;
  wire       brk_exp  = t_exp[0];
  wire       refuse   = (prio == PRIO_LOCAL) && tx_busy;                    // RULE1
  wire       rx_take  = rx_char_valid && !refuse;                          // RULE2
  wire [7:0] bcc_mask = (bcc_mode == BCC_ODD) ? 8'hff : 8'h00;
  wire [7:0] rx_par_n = rx_par_ff ^ rx_char;
  wire       hex_dig  = rx_char >= 8'h30 && rx_char <= 8'h39;
  wire       hex_let  = rx_char >= 8'h41 && rx_char <= 8'h46;
  wire [3:0] rx_nib   = hex_dig ? rx_char[3:0] : 4'(rx_char[3:0] + 4'h9);

  // ---------------- APB slave: zero wait states, reads captured in setup
  always_comb begin
    nxt_prdata = 32'h0;
    nxt_err    = 1'b0;
    if (paddr == OFS_CTRL) begin
      nxt_prdata[CTL_W-1:0] = ctrl_ff;
    end else if (paddr == OFS_BRK_TO) begin
      nxt_prdata[TIME_W-1:0] = lim_ff[0];
    end else if (paddr == OFS_RX_MON) begin
      nxt_prdata[TIME_W-1:0] = lim_ff[1];
    end else if (paddr == OFS_FDX_IV) begin
      nxt_prdata[TIME_W-1:0] = lim_ff[2];
    end else if (paddr == OFS_STATUS) begin
      nxt_prdata[NSTS-1:0] = sts_ff;
    end else if (paddr == OFS_MASK) begin
      nxt_prdata[NSTS-1:0] = mask_ff;
    end else if (paddr == OFS_TXDATA) begin
      nxt_prdata[7:0] = tx_hold_ff;
      nxt_err         = pwrite && hold_full_ff;
    end else if (paddr == OFS_RXDATA) begin
      nxt_prdata[7:0] = rx_data_ff;
    end else if (paddr == OFS_CMD) begin
      nxt_prdata[1:0] = {rx_chk_ff, bcc_req_ff};
    end else if (paddr == OFS_STATE) begin
      nxt_prdata[4:0] = {rx_active_ff, dsr_ff, rx_full_ff, hold_full_ff, tx_busy};
    end else begin
      nxt_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= psel && !penable;
      pslverr_ff <= psel && !penable && nxt_err;
      if (psel && !penable) begin
        prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
      end
    end
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      mask_ff <= '0;
      for (int i = 0; i < NTIMER; i++) begin
        lim_ff[i] <= TIME_RST;
      end
    end else if (wr_acc && !pslverr_ff) begin
      if (paddr == OFS_CTRL) begin
        ctrl_ff <= pwdata[CTL_W-1:0];
      end else if (paddr == OFS_BRK_TO) begin
        lim_ff[0] <= pwdata[TIME_W-1:0];                                  // RULE3
      end else if (paddr == OFS_RX_MON) begin
        lim_ff[1] <= pwdata[TIME_W-1:0];                                  // RULE4
      end else if (paddr == OFS_FDX_IV) begin
        lim_ff[2] <= pwdata[TIME_W-1:0];                                  // RULE5
      end else if (paddr == OFS_MASK) begin
        mask_ff <= pwdata[NSTS-1:0];
      end
    end
  end

  // sticky status, hardware set wins over write-one-to-clear
  always_comb begin
    sts_set            = '0;
    sts_set[ST_BRK]    = brk_exp;                                          // RULE12
    sts_set[ST_RXMON]  = t_exp[1];                                         // RULE12
    sts_set[ST_FDX]    = t_exp[2];
    sts_set[ST_REFUSE] = rx_char_valid && refuse;
    sts_set[ST_BCC]    = rx_take && rx_chk_ff && (rx_char != (rx_par_ff ^ bcc_mask));
    sts_set[ST_HEX]    = rx_take && !rx_chk_ff && conv && !hex_dig && !hex_let;
    sts_set[ST_RXAV]   = rx_take && !rx_chk_ff && (!conv || rx_half_ff) && (hex_dig || hex_let || !conv);
    sts_set[ST_OVR]    = sts_set[ST_RXAV] && rx_full_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      if (wr_acc && paddr == OFS_STATUS) begin
        sts_ff <= (sts_ff & ~pwdata[NSTS-1:0]) | sts_set;
      end else begin
        sts_ff <= sts_ff | sts_set;
      end
      irq_ff <= |(sts_ff & mask_ff);
    end
  end

  // ---------------- modem control pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr_meta_ff <= 1'b0;
      dsr_ff      <= 1'b0;
      rts_ff      <= 1'b0;
      ready_ff    <= 1'b0;
    end else begin
      dsr_meta_ff <= dataset_ready_in;
      dsr_ff      <= dsr_meta_ff;
      ready_ff    <= ctrl_ff[CTL_READY];                                   // RULE6
      // automatic mode raises the send request only while we have data
      rts_ff      <= ctrl_ff[CTL_AUTO] ? tx_busy : ctrl_ff[CTL_RTS];       // RULE11
    end
  end

  // ---------------- transmit path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_ff  <= TX_IDLE;
      tx_valid_ff  <= 1'b0;
      tx_char_ff   <= 8'h00;
      tx_lo_ff     <= 4'h0;
      tx_hold_ff   <= 8'h00;
      hold_full_ff <= 1'b0;
      bcc_req_ff   <= 1'b0;
      tx_par_ff    <= 8'h00;
    end else begin
      if (tx_take && tx_state_ff != TX_CHK) begin
        tx_par_ff <= tx_par_ff ^ tx_char_ff;
      end
      case (tx_state_ff)
        TX_IDLE: begin
          if (bcc_req_ff && bcc_mode == BCC_NONE) begin
            bcc_req_ff <= 1'b0;
            tx_par_ff  <= 8'h00;
          end else if (bcc_req_ff && !hold_full_ff && dsr_ok) begin
            tx_char_ff  <= tx_par_ff ^ bcc_mask;                           // RULE10
            tx_valid_ff <= 1'b1;
            tx_state_ff <= TX_CHK;
          end else if (hold_full_ff && dsr_ok) begin                       // RULE7
            hold_full_ff <= 1'b0;
            tx_valid_ff  <= 1'b1;
            tx_lo_ff     <= tx_hold_ff[3:0];
            if (conv) begin
              tx_char_ff  <= hex_char(tx_hold_ff[7:4]);                    // RULE9
              tx_state_ff <= TX_HI;
            end else begin
              tx_char_ff  <= tx_hold_ff;                                   // RULE8
              tx_state_ff <= TX_LO;
            end
          end
        end
        TX_HI: begin
          if (tx_take) begin
            tx_char_ff  <= hex_char(tx_lo_ff);                             // RULE9
            tx_state_ff <= TX_LO;
          end
        end
        TX_LO: begin
          if (tx_take) begin
            tx_valid_ff <= 1'b0;
            tx_state_ff <= TX_IDLE;
          end
        end
        default: begin
          if (tx_take) begin
            tx_valid_ff <= 1'b0;
            tx_par_ff   <= 8'h00;
            bcc_req_ff  <= 1'b0;
            tx_state_ff <= TX_IDLE;
          end
        end
      endcase
      // a stalled send is dropped so the link does not hang forever
      if (brk_exp) begin                                                   // RULE3
        tx_state_ff  <= TX_IDLE;
        tx_valid_ff  <= 1'b0;
        hold_full_ff <= 1'b0;
        bcc_req_ff   <= 1'b0;
        tx_par_ff    <= 8'h00;
      end
      if (wr_acc && !pslverr_ff && paddr == OFS_TXDATA) begin
        tx_hold_ff   <= pwdata[7:0];
        hold_full_ff <= 1'b1;
      end
      if (wr_acc && paddr == OFS_CMD && pwdata[CMD_SEND_BCC]) begin
        bcc_req_ff <= 1'b1;
      end
    end
  end

  // ---------------- receive path, independent of transmit unless refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_data_ff   <= 8'h00;
      rx_full_ff   <= 1'b0;
      rx_half_ff   <= 1'b0;
      rx_hi_ff     <= 4'h0;
      rx_par_ff    <= 8'h00;
      rx_chk_ff    <= 1'b0;
      rx_active_ff <= 1'b0;
    end else begin
      if (rd_acc && paddr == OFS_RXDATA) begin
        rx_full_ff <= 1'b0;
      end
      if (t_exp[1]) begin
        rx_active_ff <= 1'b0;
        rx_half_ff   <= 1'b0;
        rx_par_ff    <= 8'h00;
      end
      if (rx_take) begin                                                   // RULE2
        if (rx_chk_ff) begin
          rx_chk_ff    <= 1'b0;                                            // RULE10
          rx_par_ff    <= 8'h00;
          rx_active_ff <= 1'b0;
          rx_half_ff   <= 1'b0;
        end else begin
          rx_par_ff    <= rx_par_n;
          rx_active_ff <= 1'b1;
          if (!conv) begin
            rx_data_ff <= rx_char;                                         // RULE8
            rx_full_ff <= 1'b1;
          end else if (hex_dig || hex_let) begin
            rx_half_ff <= !rx_half_ff;
            rx_hi_ff   <= rx_nib;
            if (rx_half_ff) begin
              rx_data_ff <= {rx_hi_ff, rx_nib};                            // RULE9
              rx_full_ff <= 1'b1;
            end
          end
        end
      end
      if (wr_acc && paddr == OFS_CMD && pwdata[CMD_RX_CHK]) begin
        rx_chk_ff <= (bcc_mode != BCC_NONE);
      end
    end
  end

  // ---------------- time base: 1 ms and 100 ms ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_ff    <= '0;
      unit_cnt_ff  <= '0;
      ms_tick_ff   <= 1'b0;
      unit_tick_ff <= 1'b0;
    end else begin
      ms_tick_ff   <= 1'b0;
      unit_tick_ff <= 1'b0;
      if (ms_cnt_ff == 18'(MS_CYC - 1)) begin
        ms_cnt_ff  <= '0;
        ms_tick_ff <= 1'b1;
      end else begin
        ms_cnt_ff <= ms_cnt_ff + 18'h1;
      end
      if (ms_tick_ff) begin
        if (unit_cnt_ff == 7'(UNIT_MS - 1)) begin
          unit_cnt_ff  <= '0;
          unit_tick_ff <= 1'b1;
        end else begin
          unit_cnt_ff <= unit_cnt_ff + 7'h1;
        end
      end
    end
  end

  assign t_run     = {prio == PRIO_NONE, rx_active_ff,                     // RULE5
                      tx_valid_ff && !tx_char_ready || hold_full_ff && !dsr_ok};
  assign t_restart = {1'b0, rx_take, tx_take};                             // RULE4
  assign t_tick    = {ms_tick_ff, unit_tick_ff, unit_tick_ff};

  for (genvar g = 0; g < NTIMER; g++) begin : g_tmr
    interval_timer #(.W(TIME_W)) u_tmr (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (t_run[g]),
      .restart (t_restart[g]),
      .tick    (t_tick[g]),
      .limit   (lim_ff[g]),
      .expired (t_exp[g])
    );
  end

  assign prdata             = prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;
  assign irq                = irq_ff;
  assign tx_char            = tx_char_ff;
  assign tx_char_valid      = tx_valid_ff;
  assign send_request_out   = rts_ff;
  assign terminal_ready_out = ready_ff;

  // ---------------- checks
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  refuse_rx_a: assert property (rx_char_valid && prio == PRIO_LOCAL && tx_busy |=> sts_ff[ST_REFUSE]) // RULE1
    else $error("receive not refused during local transmit");
  duplex_rx_a: assert property (rx_char_valid && prio == PRIO_NONE && !conv && !rx_chk_ff // RULE2
    |=> rx_full_ff && rx_data_ff == $past(rx_char))
    else $error("full duplex receive blocked");
  break_abort_a: assert property (brk_exp && !wr_acc |=> !tx_valid_ff && sts_ff[ST_BRK]) // RULE3
    else $error("break timeout did not abort send");
  rx_monitor_a: assert property (t_exp[1] |-> rx_active_ff ##1 sts_ff[ST_RXMON] && !rx_active_ff) // RULE4
    else $error("receive monitor expiry lost");
  fdx_interval_a: assert property (t_exp[2] |-> $past(prio) == PRIO_NONE ##1 sts_ff[ST_FDX]) // RULE5
    else $error("interval outside full duplex");
  ready_pin_a: assert property (ctrl_ff[CTL_READY] [*2] |-> terminal_ready_out) // RULE6
    else $error("ready pin not held");
  dsr_gate_a: assert property (ctrl_ff[CTL_DSR] && !dsr_ff && !tx_valid_ff |=> !tx_valid_ff) // RULE7
    else $error("send started without data set ready");
  plain_tx_a: assert property (tx_state_ff == TX_IDLE && hold_full_ff && dsr_ok && !bcc_req_ff // RULE8
    && !conv && !brk_exp |=> tx_char_ff == $past(tx_hold_ff) && tx_valid_ff)
    else $error("transparent byte altered");
  ascii_tx_a: assert property (tx_state_ff == TX_HI && tx_take && !brk_exp // RULE9
    |=> tx_char_ff == hex_char($past(tx_lo_ff)) && tx_state_ff == TX_LO)
    else $error("low hex character wrong");
  bcc_tx_a: assert property (tx_state_ff == TX_IDLE && bcc_req_ff && bcc_mode == BCC_ODD // RULE10
    && !hold_full_ff && dsr_ok && !brk_exp |=> tx_char_ff == ~$past(tx_par_ff))
    else $error("odd block check wrong");
  auto_rts_a: assert property (ctrl_ff[CTL_AUTO] && tx_busy |=> send_request_out) // RULE11
    else $error("automatic send request missing");
  irq_level_a: assert property (|(sts_ff & mask_ff) |=> irq) // RULE12
    else $error("interrupt not raised");

endmodule

// ===== tb/remote_station_model.sv
// Purpose: far side of the character link, framer and remote station
// Assumes: same clock as the block, one char per valid&ready edge
// Notes:   stall and dsr are steered by the bench; sent chars queue in got
module remote_station_model (
  input  wire logic       pclk,
  input  wire logic [7:0] tx_char,
  input  wire logic       tx_char_valid,
  output logic            tx_char_ready,
  output logic [7:0]      rx_char,
  output logic            rx_char_valid,
  output logic            dataset_ready_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       stall = 1'b0;
  logic       dsr   = 1'b1;
  logic [7:0] got[$];
  initial begin
    tx_char_ready = 1'b0;
    rx_char       = 8'h00;
    rx_char_valid = 1'b0;
  end
  assign dataset_ready_in = dsr;
  always @(posedge pclk) begin
    if (tx_char_valid && tx_char_ready) got.push_back(tx_char);
    tx_char_ready <= !stall;
  end
  // idle line shows the inverse so a stale char is never mistaken for data
  task send(input logic [7:0] c);
    @(posedge pclk);
    rx_char       <= c;
    rx_char_valid <= 1'b1;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    rx_char       <= ~c;
  endtask
endmodule

// ===== tb/serial_link_protocol_control_tb_top.sv
// Purpose: self-checking bench for the serial link protocol control block
// Assumes: MS_CYC shortened to 10 so a 100 ms unit is 1000 cycles
// Notes:   APB master waits on pready as long as it takes; the watchdog bounds a hang
module serial_link_protocol_control_tb_top;
  import slp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, tx_char, rx_char;
  logic [31:0] pwdata, prdata, rdat;
  logic pready, pslverr, irq, tx_char_valid, tx_char_ready, rx_char_valid;
  logic send_request_out, terminal_ready_out, dataset_ready_in, rerr;
  int err_count = 0, compares = 0;
  serial_link_protocol_control #(.MS_CYC(10)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .tx_char(tx_char), .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready),
    .rx_char(rx_char), .rx_char_valid(rx_char_valid), .send_request_out(send_request_out),
    .terminal_ready_out(terminal_ready_out), .dataset_ready_in(dataset_ready_in));
  remote_station_model u_peer (
    .pclk(pclk), .tx_char(tx_char), .tx_char_valid(tx_char_valid), .tx_char_ready(tx_char_ready),
    .rx_char(rx_char), .rx_char_valid(rx_char_valid), .dataset_ready_in(dataset_ready_in));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task report_and_stop;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, g, x);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(rdat, x);
  endtask
  task sts(input int b, input logic x);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rdat[b], x);
  endtask
  task t_reset;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_BRK_TO, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk(rerr, 1'b1);
  endtask
  task t_plain;
    wr(OFS_CTRL, 32'h4);
    wr(OFS_TXDATA, 32'h5a);
    cyc(10);
    chk(u_peer.got[$], 8'h5a);
    chk(terminal_ready_out, 1'b1);
    wr(OFS_MASK, 32'h20);
    u_peer.send(8'ha5);
    cyc(4);
    chk(irq, 1'b1);
    rd(OFS_RXDATA, 32'ha5);
    wr(OFS_STATUS, 32'hff);
    cyc(3);
    chk(irq, 1'b0);
    wr(OFS_MASK, 32'h0);
    wr(OFS_CTRL, 32'h20);
    cyc(3);
    chk(terminal_ready_out, 1'b0);
    chk(send_request_out, 1'b1);
  endtask
  task t_ascii;
    wr(OFS_CTRL, 32'h40);
    wr(OFS_TXDATA, 32'h3c);
    cyc(12);
    chk(u_peer.got[$-1], 8'h33);
    chk(u_peer.got[$], 8'h43);
    u_peer.send(8'h41);
    u_peer.send(8'h35);
    cyc(3);
    rd(OFS_RXDATA, 32'ha5);
    u_peer.send(8'h47);
    cyc(3);
    sts(ST_HEX, 1'b1);
  endtask
  task t_bcc;
    // check request with no check mode restarts the running parity
    wr(OFS_CMD, 32'h1);
    wr(OFS_CTRL, 32'h80);
    wr(OFS_TXDATA, 32'h12);
    cyc(6);
    wr(OFS_TXDATA, 32'h34);
    wr(OFS_CMD, 32'h1);
    cyc(12);
    chk(u_peer.got[$], 8'h26);
    wr(OFS_CTRL, 32'h100);
    wr(OFS_CMD, 32'h2);
    u_peer.send(8'h00);
    cyc(3);
    sts(ST_BCC, 1'b1);
    wr(OFS_STATUS, 32'hff);
    wr(OFS_CMD, 32'h2);
    u_peer.send(8'hff);
    cyc(3);
    sts(ST_BCC, 1'b0);
  endtask
  task t_prio(input logic [1:0] p, input logic refused);
    wr(OFS_CTRL, 32'h10 | p);
    u_peer.stall <= 1'b1;
    wr(OFS_TXDATA, 32'h11);
    cyc(4);
    chk(send_request_out, 1'b1);
    u_peer.send(8'h22);
    cyc(3);
    sts(ST_REFUSE, refused);
    sts(ST_RXAV, !refused);
    u_peer.stall <= 1'b0;
    cyc(6);
    wr(OFS_STATUS, 32'hff);
  endtask
  task t_dsr;
    int n;
    n = u_peer.got.size();
    u_peer.dsr <= 1'b0;
    wr(OFS_CTRL, 32'h8);
    wr(OFS_TXDATA, 32'h77);
    wr(OFS_TXDATA, 32'h55);
    chk(rerr, 1'b1);
    cyc(20);
    chk(u_peer.got.size(), n);
    u_peer.dsr <= 1'b1;
    cyc(10);
    chk(u_peer.got[$], 8'h77);
  endtask
  task t_timers;
    int n;
    wr(OFS_CTRL, 32'h0);
    wr(OFS_FDX_IV, 32'h2);
    cyc(45);
    sts(ST_FDX, 1'b1);
    wr(OFS_FDX_IV, 32'h0);
    wr(OFS_BRK_TO, 32'h1);
    n = u_peer.got.size();
    u_peer.stall <= 1'b1;
    wr(OFS_TXDATA, 32'h99);
    cyc(1300);
    sts(ST_BRK, 1'b1);
    u_peer.stall <= 1'b0;
    cyc(6);
    chk(u_peer.got.size(), n);
    wr(OFS_STATUS, 32'hff);
    sts(ST_BRK, 1'b0);
    wr(OFS_RX_MON, 32'h1);
    u_peer.send(8'h01);
    cyc(1300);
    sts(ST_RXMON, 1'b1);
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    report_and_stop();
  end
  initial begin
    presetn <= 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    cyc(8);
    presetn <= 1'b1;
    t_reset();
    t_plain();
    t_ascii();
    t_bcc();
    t_prio(PRIO_LOCAL, 1'b1);
    t_prio(PRIO_NONE, 1'b0);
    t_prio(PRIO_REMOTE, 1'b0);
    t_dsr();
    t_timers();
    report_and_stop();
  end
endmodule
